// ### design/isr_status_core.v
// Status byte, enable masks, event latch, output queue and remote state handling
`default_nettype none
`include "isr_defines.vh"
module isr_status_core #(
   parameter QDEPTH_LOG2 = 4
)(
   input wire mclk,
   input wire rst_n,
   input wire [3:0] cmd_code,
   input wire cmd_valid,
   input wire [7:0] cmd_value,
   input wire q_wr_en,
   input wire [7:0] q_wr_data,
   input wire q_rd_req,
   input wire serial_poll,
   input wire ev_syntax_err,
   input wire ev_run_fault,
   input wire ev_device_fault,
   input wire ev_adapter_pin,
   input wire ops_pending,
   input wire local_key,
   input wire [7:0] panel_keys,
   output reg [7:0] reply_data,
   output reg reply_valid,
   output reg [7:0] q_rd_data,
   output reg q_rd_valid,
   output reg [7:0] status_summary_byte,
   output reg srq_out,
   output reg poll_byte_valid,
   output reg [7:0] poll_byte,
   output reg remote_mode,
   output reg lockout_mode,
   output reg [7:0] panel_keys_out
);
   reg [7:0] request_enable_mask_reg;
   reg [7:0] event_enable_mask_reg;
   reg [15:0] event_latch_register_reg;
   reg [15:0] event_latch_next;
   reg service_request_flag_reg;
   reg done_armed_reg;
   reg prev_evsum_reg;
   reg prev_wait_reg;
   reg powerup_event_reg;
   reg adp_s1_reg;
   reg adp_s2_reg;
   reg adp_prev_reg;
   reg lkey_s1_reg;
   reg lkey_s2_reg;
   reg [7:0] keys_s1_reg;
   reg [7:0] keys_s2_reg;
   reg q_rd_pend_reg;
   wire q_empty;
   wire q_full;
   wire [7:0] q_data;
   wire q_rd_ok;
   wire message_waiting;
   wire event_summary_bit;
   wire master_summary;
   wire evsum_rise;
   wire wait_rise;
   wire adapter_change_event;
   wire query_fault_event;
   wire is_cmd;

   function is_op;
      input [3:0] code;
      input [3:0] want;
      input valid;
      begin
         is_op = valid && (code == want);
      end
   endfunction

   // Summary byte layout shared by status, poll and query answers
   function [7:0] sum_byte;
      input req_bit;
      input ev_bit;
      input wait_bit;
      begin
         sum_byte = {1'b0, req_bit, ev_bit, wait_bit, 4'h0};
      end
   endfunction

   assign is_cmd = cmd_valid;
   assign q_rd_ok = q_rd_req && !q_empty;
   assign message_waiting = !q_empty;
   assign event_summary_bit = |(event_latch_register_reg[7:0] & event_enable_mask_reg);
   assign master_summary = (event_summary_bit & request_enable_mask_reg[`ISR_SUM_EVENT_BIT]) |
      (message_waiting & request_enable_mask_reg[`ISR_SUM_WAIT_BIT]);
   assign evsum_rise = event_summary_bit && !prev_evsum_reg;
   assign wait_rise = message_waiting && !prev_wait_reg;
   assign adapter_change_event = adp_s2_reg ^ adp_prev_reg;
   assign query_fault_event = (q_rd_req && q_empty) || (q_wr_en && q_full);

   isr_out_queue #(
      .WIDTH(8),
      .DEPTH_LOG2(QDEPTH_LOG2)
   ) u_queue (
      .mclk(mclk),
      .rst_n(rst_n),
      .wr_en(q_wr_en),
      .wr_data(q_wr_data),
      .rd_en(q_rd_ok),
      .rd_data(q_data),
      .empty(q_empty),
      .full(q_full)
   );

   // Event latch next value, events set after any clear so none are lost
   always @*
   begin
      event_latch_next = event_latch_register_reg;
      if (is_op(cmd_code, `ISR_CMD_LATCH_Q, is_cmd) || is_op(cmd_code, `ISR_CMD_CLEAR, is_cmd))
         event_latch_next = `ISR_LATCH_RST;
      if (powerup_event_reg)
         event_latch_next[`ISR_EV_POWER] = 1'b1;
      if (adapter_change_event)
         event_latch_next[`ISR_EV_ADAPTER] = 1'b1;
      if (ev_syntax_err)
         event_latch_next[`ISR_EV_SYNTAX] = 1'b1;
      if (ev_run_fault)
         event_latch_next[`ISR_EV_RUN] = 1'b1;
      if (ev_device_fault)
         event_latch_next[`ISR_EV_DEVICE] = 1'b1;
      if (query_fault_event)
         event_latch_next[`ISR_EV_QUERY] = 1'b1;
      if (done_armed_reg && !ops_pending)
         event_latch_next[`ISR_EV_DONE] = 1'b1;
      event_latch_next[15:8] = 8'h00;
   end

   // Input synchronisers
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         adp_s1_reg <= 1'b0;
         adp_s2_reg <= 1'b0;
         lkey_s1_reg <= 1'b0;
         lkey_s2_reg <= 1'b0;
         keys_s1_reg <= 8'h00;
         keys_s2_reg <= 8'h00;
      end
      else
      begin
         adp_s1_reg <= ev_adapter_pin;
         adp_s2_reg <= adp_s1_reg;
         lkey_s1_reg <= local_key;
         lkey_s2_reg <= lkey_s1_reg;
         keys_s1_reg <= panel_keys;
         keys_s2_reg <= keys_s1_reg;
      end
   end

   // Enable masks
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         request_enable_mask_reg <= `ISR_REQ_MASK_RST;
         event_enable_mask_reg <= `ISR_EV_MASK_RST;
      end
      else
      begin
         if (is_op(cmd_code, `ISR_CMD_REQ_W, is_cmd))
            request_enable_mask_reg <= cmd_value & `ISR_REQ_MASK_KEEP;
         if (is_op(cmd_code, `ISR_CMD_EVM_W, is_cmd))
            event_enable_mask_reg <= cmd_value;
      end
   end

   // Event latch and its edge history
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         event_latch_register_reg <= `ISR_LATCH_RST;
         powerup_event_reg <= 1'b1;
         adp_prev_reg <= 1'b0;
         done_armed_reg <= 1'b0;
         prev_evsum_reg <= 1'b0;
         prev_wait_reg <= 1'b0;
      end
      else
      begin
         event_latch_register_reg <= event_latch_next;
         powerup_event_reg <= 1'b0;
         adp_prev_reg <= adp_s2_reg;
         prev_evsum_reg <= event_summary_bit;
         prev_wait_reg <= message_waiting;
         if (is_op(cmd_code, `ISR_CMD_DONE, is_cmd))
            done_armed_reg <= 1'b1;
         else if (done_armed_reg && !ops_pending)
            done_armed_reg <= 1'b0;
      end
   end

   // Request flag: rising enabled summary sets, poll or clear-status clears
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         service_request_flag_reg <= 1'b0;
         srq_out <= 1'b0;
         status_summary_byte <= 8'h00;
         poll_byte <= 8'h00;
         poll_byte_valid <= 1'b0;
      end
      else
      begin
         if ((evsum_rise && request_enable_mask_reg[`ISR_SUM_EVENT_BIT]) ||
             (wait_rise && request_enable_mask_reg[`ISR_SUM_WAIT_BIT]))
            service_request_flag_reg <= 1'b1;
         else if (serial_poll || is_op(cmd_code, `ISR_CMD_CLEAR, is_cmd))
            service_request_flag_reg <= 1'b0;
         srq_out <= service_request_flag_reg;
         status_summary_byte <= sum_byte(service_request_flag_reg, event_summary_bit,
            message_waiting);
         poll_byte_valid <= serial_poll;
         if (serial_poll)
            poll_byte <= sum_byte(service_request_flag_reg, event_summary_bit,
               message_waiting);
      end
   end

   // Query answers
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reply_data <= 8'h00;
         reply_valid <= 1'b0;
      end
      else
      begin
         reply_valid <= 1'b0;
         if (is_cmd)
         begin
            case (cmd_code)
               `ISR_CMD_SUM_Q:
               begin
                  reply_data <= sum_byte(master_summary, event_summary_bit,
                     message_waiting);
                  reply_valid <= 1'b1;
               end
               `ISR_CMD_REQ_Q:
               begin
                  reply_data <= request_enable_mask_reg;
                  reply_valid <= 1'b1;
               end
               `ISR_CMD_LATCH_Q:
               begin
                  reply_data <= event_latch_register_reg[7:0];
                  reply_valid <= 1'b1;
               end
               `ISR_CMD_EVM_Q:
               begin
                  reply_data <= event_enable_mask_reg;
                  reply_valid <= 1'b1;
               end
               default:
                  reply_valid <= 1'b0;
            endcase
         end
      end
   end

   // Remote, lockout and panel gating
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         remote_mode <= 1'b0;
         lockout_mode <= 1'b0;
         panel_keys_out <= 8'h00;
      end
      else
      begin
         if (is_op(cmd_code, `ISR_CMD_TAKEOVER, is_cmd))
            remote_mode <= 1'b1;
         else if (is_op(cmd_code, `ISR_CMD_RETURN, is_cmd))
            remote_mode <= 1'b0;
         else if (!is_cmd && remote_mode && !lockout_mode && lkey_s2_reg)
            remote_mode <= 1'b0;
         if (is_op(cmd_code, `ISR_CMD_LOCKOUT, is_cmd))
            lockout_mode <= 1'b1;
         else if (is_op(cmd_code, `ISR_CMD_UNLOCK, is_cmd))
            lockout_mode <= 1'b0;
         // Panel keys pass only in local mode
         panel_keys_out <= remote_mode ? 8'h00 : keys_s2_reg;
      end
   end

   // Queue read: data valid one cycle after the fetch
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q_rd_pend_reg <= 1'b0;
         q_rd_valid <= 1'b0;
         q_rd_data <= 8'h00;
      end
      else
      begin
         q_rd_pend_reg <= q_rd_ok;
         q_rd_valid <= q_rd_pend_reg;
         if (q_rd_pend_reg)
            q_rd_data <= q_data;
      end
   end
endmodule // isr_status_core
`default_nettype wire

// ### design/isr_defines.vh
// Bit positions, command codes and reset values of the status reporting block
`ifndef ISR_DEFINES_VH
`define ISR_DEFINES_VH
`define ISR_SUM_WAIT_BIT 4
`define ISR_SUM_EVENT_BIT 5
`define ISR_SUM_REQ_BIT 6
`define ISR_REQ_MASK_KEEP 8'hbf
`define ISR_REQ_MASK_RST 8'h00
`define ISR_EV_MASK_RST 8'h00
`define ISR_LATCH_RST 16'h0000
`define ISR_EV_DONE 0
`define ISR_EV_QUERY 2
`define ISR_EV_DEVICE 3
`define ISR_EV_RUN 4
`define ISR_EV_SYNTAX 5
`define ISR_EV_ADAPTER 6
`define ISR_EV_POWER 7
`define ISR_CMD_NONE 4'h0
`define ISR_CMD_SUM_Q 4'h1
`define ISR_CMD_REQ_W 4'h2
`define ISR_CMD_REQ_Q 4'h3
`define ISR_CMD_LATCH_Q 4'h4
`define ISR_CMD_EVM_W 4'h5
`define ISR_CMD_EVM_Q 4'h6
`define ISR_CMD_CLEAR 4'h7
`define ISR_CMD_TAKEOVER 4'h8
`define ISR_CMD_RETURN 4'h9
`define ISR_CMD_LOCKOUT 4'ha
`define ISR_CMD_UNLOCK 4'hb
`define ISR_CMD_DONE 4'hc
`endif

// ### design/isr_out_queue.v
// Output message queue holding response bytes in arrival order
`default_nettype none
module isr_out_queue #(
   parameter WIDTH = 8,
   parameter DEPTH_LOG2 = 4
)(
   input wire mclk,
   input wire rst_n,
   input wire wr_en,
   input wire [WIDTH-1:0] wr_data,
   input wire rd_en,
   output reg [WIDTH-1:0] rd_data,
   output wire empty,
   output wire full
);
   localparam DEPTH = 1 << DEPTH_LOG2;
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [DEPTH_LOG2:0] wr_ptr_reg;
   reg [DEPTH_LOG2:0] rd_ptr_reg;
   wire do_wr;
   wire do_rd;
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[DEPTH_LOG2] != rd_ptr_reg[DEPTH_LOG2]) &&
      (wr_ptr_reg[DEPTH_LOG2-1:0] == rd_ptr_reg[DEPTH_LOG2-1:0]);
   assign do_wr = wr_en && !full;
   assign do_rd = rd_en && !empty;
   // First in first out
   always @(posedge mclk)
   begin
      if (do_wr)
         mem[wr_ptr_reg[DEPTH_LOG2-1:0]] <= wr_data;
   end
   // Power-on empties the queue
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= {(DEPTH_LOG2+1){1'b0}};
         rd_ptr_reg <= {(DEPTH_LOG2+1){1'b0}};
         rd_data <= {WIDTH{1'b0}};
      end
      else
      begin
         if (do_wr)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_rd)
         begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
            rd_data <= mem[rd_ptr_reg[DEPTH_LOG2-1:0]];
         end
      end
   end
endmodule // isr_out_queue
`default_nettype wire

// ### dv/isr_status_sva.sv
// Port assertions for the status reporting core
`default_nettype none
module isr_status_sva (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] cmd_code,
   input wire logic cmd_valid,
   input wire logic q_rd_req,
   input wire logic serial_poll,
   input wire logic reply_valid,
   input wire logic [7:0] reply_data,
   input wire logic q_rd_valid,
   input wire logic [7:0] status_summary_byte,
   input wire logic srq_out,
   input wire logic poll_byte_valid,
   input wire logic remote_mode,
   input wire logic lockout_mode,
   input wire logic [7:0] panel_keys_out
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   chk_reply_cause: assert property (reply_valid |-> $past(cmd_valid) &&
      $past(cmd_code) inside {4'h1, 4'h3, 4'h4, 4'h6}) else $error("reply without query");
   chk_mask_bit6: assert property ($past(cmd_valid && cmd_code == 4'h3) |->
      reply_valid && !reply_data[6]) else $error("mask bit 6 not zero");
   chk_queue_read: assert property (q_rd_valid |-> $past(q_rd_req, 2))
      else $error("queue byte without read");
   chk_poll_cause: assert property (poll_byte_valid |-> $past(serial_poll) ||
      $past(serial_poll, 2)) else $error("poll answer without poll");
   chk_srq_flag: assert property (srq_out |-> status_summary_byte[6] ||
      $past(status_summary_byte[6])) else $error("srq without flag");
   chk_remote_on: assert property ($past(cmd_valid && cmd_code == 4'h8) |->
      remote_mode) else $error("takeover ignored");
   chk_lock_on: assert property ($past(cmd_valid && cmd_code == 4'ha) |->
      lockout_mode) else $error("lockout ignored");
   chk_panel_gate: assert property (remote_mode && $past(remote_mode) |->
      panel_keys_out == 8'h00) else $error("panel keys pass in remote");
endmodule // isr_status_sva
bind isr_status_core isr_status_sva i_sva (.mclk(mclk), .rst_n(rst_n), .cmd_code(cmd_code),
   .cmd_valid(cmd_valid), .q_rd_req(q_rd_req), .serial_poll(serial_poll),
   .reply_valid(reply_valid), .reply_data(reply_data), .q_rd_valid(q_rd_valid),
   .status_summary_byte(status_summary_byte), .srq_out(srq_out),
   .poll_byte_valid(poll_byte_valid), .remote_mode(remote_mode),
   .lockout_mode(lockout_mode), .panel_keys_out(panel_keys_out));
`default_nettype wire

// ### dv/isr_host_model.sv
// Host side model: commands, queue reads and serial polls
`default_nettype none
module isr_host_model (
   input wire logic mclk,
   input wire logic reply_valid,
   input wire logic [7:0] reply_data,
   input wire logic q_rd_valid,
   input wire logic [7:0] q_rd_data,
   input wire logic poll_byte_valid,
   input wire logic [7:0] poll_byte,
   input wire logic [7:0] status_summary_byte,
   output logic [3:0] cmd_code = 4'h0,
   output logic cmd_valid = 1'b0,
   output logic [7:0] cmd_value = 8'h00,
   output logic q_rd_req = 1'b0,
   output logic serial_poll = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   task send(input logic [3:0] c, input logic [7:0] v, output logic ok, output logic [7:0] d);
      @(posedge mclk);
      cmd_code <= c;
      cmd_value <= v;
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd_value <= ~v;
      #1;
      ok = reply_valid;
      d = reply_data;
   endtask
   task read_q(input logic w, output logic ok, output logic [7:0] d);
      repeat (20) if (w && !status_summary_byte[4]) @(posedge mclk);
      @(posedge mclk);
      q_rd_req <= 1'b1;
      @(posedge mclk);
      q_rd_req <= 1'b0;
      @(posedge mclk);
      #1;
      ok = q_rd_valid;
      d = q_rd_data;
   endtask
   task poll(output logic ok, output logic [7:0] d);
      @(posedge mclk);
      serial_poll <= 1'b1;
      @(posedge mclk);
      serial_poll <= 1'b0;
      #1;
      ok = poll_byte_valid;
      d = poll_byte;
   endtask
endmodule // isr_host_model
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the status reporting core
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [3:0] w; logic [7:0] v; logic [7:0] e;} isr_row_t;
   isr_row_t rows [4] = '{'{4'h2, 8'hff, 8'hbf}, '{4'h2, 8'h00, 8'h00},
      '{4'h5, 8'ha5, 8'ha5}, '{4'h5, 8'hff, 8'hff}};
   logic mclk = 0, rst_n = 0, q_wr_en = 0, ev_syntax_err = 0, ev_run_fault = 0;
   logic ev_device_fault = 0, ev_adapter_pin = 0, ops_pending = 0, local_key = 0;
   logic [7:0] q_wr_data = 8'h00, panel_keys = 8'h00, reply_data, q_rd_data, d;
   logic [7:0] status_summary_byte, poll_byte, panel_keys_out;
   logic [3:0] cmd_code;
   logic [7:0] cmd_value;
   logic cmd_valid, q_rd_req, serial_poll, reply_valid, q_rd_valid, srq_out, ok;
   logic poll_byte_valid, remote_mode, lockout_mode;
   int failures = 0, n_tests = 0;
   always #50 mclk = ~mclk;
   isr_status_core i_isr_status_core (.mclk(mclk), .rst_n(rst_n), .cmd_code(cmd_code),
      .cmd_valid(cmd_valid), .cmd_value(cmd_value), .q_wr_en(q_wr_en),
      .q_wr_data(q_wr_data), .q_rd_req(q_rd_req), .serial_poll(serial_poll),
      .ev_syntax_err(ev_syntax_err), .ev_run_fault(ev_run_fault),
      .ev_device_fault(ev_device_fault), .ev_adapter_pin(ev_adapter_pin),
      .ops_pending(ops_pending), .local_key(local_key), .panel_keys(panel_keys),
      .reply_data(reply_data), .reply_valid(reply_valid), .q_rd_data(q_rd_data),
      .q_rd_valid(q_rd_valid), .status_summary_byte(status_summary_byte),
      .srq_out(srq_out), .poll_byte_valid(poll_byte_valid), .poll_byte(poll_byte),
      .remote_mode(remote_mode), .lockout_mode(lockout_mode),
      .panel_keys_out(panel_keys_out));
   isr_host_model host (.mclk(mclk), .reply_valid(reply_valid), .reply_data(reply_data),
      .q_rd_valid(q_rd_valid), .q_rd_data(q_rd_data), .poll_byte_valid(poll_byte_valid),
      .poll_byte(poll_byte), .status_summary_byte(status_summary_byte),
      .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_value(cmd_value),
      .q_rd_req(q_rd_req), .serial_poll(serial_poll));
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task q(input logic [3:0] c, input logic [7:0] e);
      host.send(c, 8'h00, ok, d);
      chk("reply_valid", 8'h01, ok);
      chk("reply_data", e, d);
   endtask
   task w(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task ev(input logic [2:0] m);
      @(posedge mclk);
      {ev_syntax_err, ev_run_fault, ev_device_fault} <= m;
      @(posedge mclk);
      {ev_syntax_err, ev_run_fault, ev_device_fault} <= 3'b000;
   endtask
   task close_out;
      $display("Checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      q(4'h4, 8'h80);
      q(4'h4, 8'h00);
      q(4'h3, 8'h00);
      q(4'h6, 8'h00);
      foreach (rows[i])
      begin
         host.send(rows[i].w, rows[i].v, ok, d);
         q(rows[i].w + 4'h1, rows[i].e);
      end
      host.send(4'hf, 8'h00, ok, d);
      chk("reply_valid", 8'h00, ok);
      @(posedge mclk);
      ops_pending <= 1'b1;
      host.send(4'hc, 8'h00, ok, d);
      ev(3'b111);
      ev_adapter_pin <= 1'b1;
      host.read_q(1'b0, ok, d);
      chk("q_rd_valid", 8'h00, ok);
      w(6);
      chk("srq_out", 8'h00, srq_out);
      chk("status_summary_byte", 8'h20, status_summary_byte);
      q(4'h4, 8'h7c);
      @(posedge mclk);
      ops_pending <= 1'b0;
      w(3);
      q(4'h4, 8'h01);
      w(3);
      chk("status_summary_byte", 8'h00, status_summary_byte);
      host.send(4'h2, 8'h20, ok, d);
      ev(3'b100);
      w(4);
      chk("status_summary_byte", 8'h60, status_summary_byte);
      chk("srq_out", 8'h01, srq_out);
      q(4'h1, 8'h60);
      host.poll(ok, d);
      chk("poll_byte_valid", 8'h01, ok);
      chk("poll_byte", 8'h60, d);
      w(3);
      chk("srq_out", 8'h00, srq_out);
      q(4'h1, 8'h60);
      host.send(4'h7, 8'h00, ok, d);
      w(3);
      chk("status_summary_byte", 8'h00, status_summary_byte);
      @(posedge mclk);
      q_wr_en <= 1'b1;
      q_wr_data <= 8'haa;
      @(posedge mclk);
      q_wr_data <= 8'h55;
      @(posedge mclk);
      q_wr_en <= 1'b0;
      host.send(4'h7, 8'h00, ok, d);
      w(3);
      chk("status_summary_byte", 8'h10, status_summary_byte);
      host.read_q(1'b1, ok, d);
      chk("q_rd_valid", 8'h01, ok);
      chk("q_rd_data", 8'haa, d);
      host.read_q(1'b1, ok, d);
      chk("q_rd_data", 8'h55, d);
      w(3);
      chk("status_summary_byte", 8'h00, status_summary_byte);
      @(posedge mclk);
      panel_keys <= 8'h5a;
      host.send(4'h8, 8'h00, ok, d);
      host.send(4'ha, 8'h00, ok, d);
      @(posedge mclk);
      local_key <= 1'b1;
      w(6);
      chk("remote_mode", 8'h01, remote_mode);
      chk("panel_keys_out", 8'h00, panel_keys_out);
      chk("lockout_mode", 8'h01, lockout_mode);
      @(posedge mclk);
      local_key <= 1'b0;
      host.send(4'hb, 8'h00, ok, d);
      @(posedge mclk);
      local_key <= 1'b1;
      w(6);
      chk("remote_mode", 8'h00, remote_mode);
      chk("lockout_mode", 8'h00, lockout_mode);
      chk("panel_keys_out", 8'h5a, panel_keys_out);
      close_out();
   end
   initial
   begin
      #500000;
      failures++;
      close_out();
   end
endmodule // testbench
`default_nettype wire
